// *** hw/actuator_op_regs.svh ***
// register offsets, reset values, ranges and codes of the operation map
// assumes word addressing, one 16-bit word per address
`ifndef ACTUATOR_OP_REGS_SVH
`define ACTUATOR_OP_REGS_SVH

`define ADDR_POSITION_SETPOINT 16'h0000
`define ADDR_OVERRIDE_SELECT 16'h0001
`define ADDR_SERVICE_COMMAND 16'h0002
`define ADDR_ACTUATOR_KIND 16'h0003
`define ADDR_RELATIVE_POSITION 16'h0004
`define ADDR_ABSOLUTE_POSITION 16'h0005
`define ADDR_RELATIVE_FLOW 16'h0006
`define ADDR_ABSOLUTE_FLOW_BASIC 16'h0007
`define ADDR_SENSOR_INPUT_VALUE 16'h0008
`define ADDR_UNUSED_SLOT 16'h0009
`define ADDR_FLOW_SELECTED_UNIT_LO 16'h000A
`define ADDR_FLOW_SELECTED_UNIT_HI 16'h000B
`define ADDR_ANALOG_SETPOINT_COPY 16'h000C

`define RST_POSITION_SETPOINT 16'h0000
`define RST_OVERRIDE_SELECT 3'h0
`define RST_SERVICE_COMMAND 3'h0

`define PERCENT_FULL 16'h2710
`define PERCENT_ZERO 16'h0000
`define WORD_UNSUPPORTED 16'hFFFF

`define FUNC_READ_HOLDING 8'h03
`define FUNC_READ_INPUT 8'h04
`define FUNC_WRITE_SINGLE 8'h06
`define EXC_ILLEGAL_FUNCTION 16'h0001

`define SENSOR_KIND_ACTIVE 16'h0001
`define SENSOR_KIND_SWITCH 16'h0004

`endif

// *** hw/actuator_op_pkg.sv ***
// types shared by the operation register map, its fieldbus master model and its bench
// assumes actuator_op_regs.svh holds the numeric constants
package actuator_op_pkg;

  typedef struct packed {
    logic [7:0] func;
    logic [15:0] addr;
    logic [15:0] data;
  } bus_req_t;

  typedef struct packed {
    logic err;
    logic [15:0] data;
  } bus_ans_t;

  typedef struct packed {
    logic [15:0] actuator_kind;
    logic [15:0] relative_position;
    logic [15:0] absolute_position;
    logic [15:0] relative_flow;
    logic [15:0] absolute_flow_basic;
    logic [15:0] sensor_millivolt;
    logic sensor_switch;
    logic [31:0] flow_selected_unit;
    logic [15:0] analog_setpoint;
    logic analog_mode;
  } plant_state_t;

  typedef struct packed {
    logic adaption;
    logic test_run;
    logic sync;
    logic fault_clear;
  } service_pulse_t;

  typedef enum logic [2:0] {
    OVR_NONE = 3'h0,
    OVR_OPEN = 3'h1,
    OVR_CLOSE = 3'h2,
    OVR_MIN = 3'h3,
    OVR_MID = 3'h4,
    OVR_MAX = 3'h5
  } override_t;

  typedef enum logic [2:0] {
    SVC_NONE = 3'h0,
    SVC_ADAPTION = 3'h1,
    SVC_TEST = 3'h2,
    SVC_SYNC = 3'h3,
    SVC_CLEAR_FAULT = 3'h4
  } service_cmd_t;

endpackage

// *** hw/flow_word_snapshot.sv ***
// holds the upper half of the 32-bit selected-unit flow taken at a low-word read
// assumes the caller pulses capture on a low-word read and release on a high-word read
`timescale 1ns/100ps
module flow_word_snapshot #(
  parameter int WIDTH = 32
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic capture, // low half being read
  input wire logic release_snap, // high half has been read
  input wire logic [WIDTH-1:0] flow_in, // live flow value
  output logic [WIDTH/2-1:0] upper_half_word, // held upper half
  output logic held // upper half is from a low-word read
);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      upper_half_word <= '0;
    end else if (capture) begin
      upper_half_word <= flow_in[WIDTH-1:WIDTH/2];
    end
  end

  // a fresh capture wins over a release in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      held <= 1'b0;
    end else if (capture) begin
      held <= 1'b1;
    end else if (release_snap) begin
      held <= 1'b0;
    end
  end

endmodule

// *** hw/actuator_operation_register_map.sv ***
// operation register bank of a flow-control actuator, served by fieldbus requests
// assumes framing is done outside: one decoded request per REQ_VALID cycle
// Overview of operation
// - setpoint at 0, 0..10000 in 0.01 %, reset 0, bounded by min/max.
// - override at 1 replaces setpoint: none, open, close, min, mid, max.
// - command at 2: none, adaption, test, sync, clear fault information.
// - command register returns to zero after any command is accepted.
// - command 4 clears every malfunction and service information bit.
// - actuator kind at 3 is read-only; 0 means nothing connected.
// - absolute position at 5, scaling 1, degrees or millimetres.
// - relative flow at 6, read-only, 0..10000 in 0.01 %.
// - sensor at 8 in mV for active kind, 0/1 for switch kind.
// - sensor reading depends on sensor kind, range 0..65535.
// - address 10 holds low 16 bits of 32-bit selected-unit flow.
// - address 11 holds high 16 bits of the same flow value.
// - selected-unit flow counts 0.001 of the chosen unit.
// - address 12 copies analog setpoint 0..10000 when driven analog.
// - unsupported registers read as 65535.
// - all registers served by read holding and write single requests.
`timescale 1ns/100ps
`include "actuator_op_regs.svh"
module actuator_operation_register_map
  import actuator_op_pkg::*;
(
  input wire logic CLK, // system clock, 200 MHz
  input wire logic RST, // async reset, high
  input wire logic REQ_VALID, // one decoded request this cycle
  input wire bus_req_t REQ, // function, address, write data
  output logic ANS_VALID, // answer ready, one cycle
  output bus_ans_t ANS, // answer word or exception
  input wire plant_state_t PLANT, // live actuator readings
  input wire logic [15:0] LIMIT_MIN, // minimum limit, 0.01 %
  input wire logic [15:0] LIMIT_MAX, // maximum limit, 0.01 %
  input wire logic [15:0] SENSOR_KIND, // configured sensor kind
  output logic [15:0] POS_DEMAND, // effective position demand, 0.01 %
  output service_pulse_t SERVICE // service command pulses
);

  logic [15:0] sp_reg;
  override_t ovr_reg;
  service_cmd_t cmd_reg;
  service_pulse_t pulse_next;
  logic [15:0] demand_next;
  logic [15:0] rd_word;
  logic [16:0] mid_sum;
  logic wr_req;
  logic rd_req;
  logic snap_held;
  logic [15:0] snap_upper;

  function automatic logic func_is_read(input logic [7:0] f);
    func_is_read = (f == `FUNC_READ_HOLDING) || (f == `FUNC_READ_INPUT);
  endfunction

  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    if (v < lo) begin
      clamp = lo;
    end else if (v > hi) begin
      clamp = hi;
    end else begin
      clamp = v;
    end
  endfunction

  assign rd_req = REQ_VALID && func_is_read(REQ.func);
  assign wr_req = REQ_VALID && (REQ.func == `FUNC_WRITE_SINGLE);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sp_reg <= `RST_POSITION_SETPOINT;
    end else if (wr_req && REQ.addr == `ADDR_POSITION_SETPOINT
                 && REQ.data <= `PERCENT_FULL) begin
      sp_reg <= REQ.data;
    end
  end

  // unknown override codes are dropped so the demand stays defined
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ovr_reg <= override_t'(`RST_OVERRIDE_SELECT);
    end else if (wr_req && REQ.addr == `ADDR_OVERRIDE_SELECT
                 && REQ.data <= 16'(OVR_MAX)) begin
      ovr_reg <= override_t'(REQ.data[2:0]);
    end
  end

  // code held one cycle, then back to none; a new write wins over the return
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cmd_reg <= service_cmd_t'(`RST_SERVICE_COMMAND);
    end else if (wr_req && REQ.addr == `ADDR_SERVICE_COMMAND
                 && REQ.data <= 16'(SVC_CLEAR_FAULT)) begin
      cmd_reg <= service_cmd_t'(REQ.data[2:0]);
    end else begin
      cmd_reg <= SVC_NONE;
    end
  end

  always_comb begin
    pulse_next = '0;
    case (cmd_reg)
      SVC_ADAPTION: pulse_next.adaption = 1'b1;
      SVC_TEST: pulse_next.test_run = 1'b1;
      SVC_SYNC: pulse_next.sync = 1'b1;
      SVC_CLEAR_FAULT: pulse_next.fault_clear = 1'b1;
      default: pulse_next = '0;
    endcase
  end

  // one pulse per accepted command, issued one cycle after the code, once it has returned to none
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      SERVICE <= '0;
    end else begin
      SERVICE <= pulse_next;
    end
  end

  assign mid_sum = {1'b0, LIMIT_MIN} + {1'b0, LIMIT_MAX};

  always_comb begin
    case (ovr_reg)
      OVR_NONE: demand_next = clamp(sp_reg, LIMIT_MIN, LIMIT_MAX);
      OVR_OPEN: demand_next = `PERCENT_FULL;
      OVR_CLOSE: demand_next = `PERCENT_ZERO;
      OVR_MIN: demand_next = LIMIT_MIN;
      OVR_MID: demand_next = mid_sum[16:1];
      OVR_MAX: demand_next = LIMIT_MAX;
      default: demand_next = clamp(sp_reg, LIMIT_MIN, LIMIT_MAX);
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      POS_DEMAND <= `PERCENT_ZERO;
    end else begin
      POS_DEMAND <= demand_next;
    end
  end

  // low-word read freezes the upper half so a pair read stays coherent
  flow_word_snapshot #(
    .WIDTH(32)
  ) i_flow_word_snapshot (
    .clk(CLK),
    .rst(RST),
    .capture(rd_req && REQ.addr == `ADDR_FLOW_SELECTED_UNIT_LO),
    .release_snap(rd_req && REQ.addr == `ADDR_FLOW_SELECTED_UNIT_HI),
    .flow_in(PLANT.flow_selected_unit),
    .upper_half_word(snap_upper),
    .held(snap_held)
  );

  always_comb begin
    case (REQ.addr)
      `ADDR_POSITION_SETPOINT: rd_word = sp_reg;
      `ADDR_OVERRIDE_SELECT: rd_word = {13'h0000, ovr_reg};
      `ADDR_SERVICE_COMMAND: rd_word = {13'h0000, cmd_reg};
      `ADDR_ACTUATOR_KIND: rd_word = PLANT.actuator_kind;
      `ADDR_RELATIVE_POSITION: rd_word = PLANT.relative_position;
      `ADDR_ABSOLUTE_POSITION: rd_word = PLANT.absolute_position;
      `ADDR_RELATIVE_FLOW: rd_word = PLANT.relative_flow;
      `ADDR_ABSOLUTE_FLOW_BASIC: rd_word = PLANT.absolute_flow_basic;
      `ADDR_SENSOR_INPUT_VALUE: begin
        if (SENSOR_KIND == `SENSOR_KIND_ACTIVE) begin
          rd_word = PLANT.sensor_millivolt;
        end else if (SENSOR_KIND == `SENSOR_KIND_SWITCH) begin
          rd_word = {15'h0000, PLANT.sensor_switch};
        end else begin
          rd_word = `WORD_UNSUPPORTED;
        end
      end
      // counts are 0.001 of the selected unit; no rescaling here
      `ADDR_FLOW_SELECTED_UNIT_LO: rd_word = PLANT.flow_selected_unit[15:0];
      `ADDR_FLOW_SELECTED_UNIT_HI: begin
        rd_word = snap_held ? snap_upper : PLANT.flow_selected_unit[31:16];
      end
      `ADDR_ANALOG_SETPOINT_COPY: begin
        rd_word = PLANT.analog_mode ? PLANT.analog_setpoint : `WORD_UNSUPPORTED;
      end
      default: rd_word = `WORD_UNSUPPORTED;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ANS_VALID <= 1'b0;
    end else begin
      ANS_VALID <= REQ_VALID;
    end
  end

  // writes echo the written word, as the fieldbus answer expects
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ANS <= '0;
    end else if (rd_req) begin
      ANS <= '{err: 1'b0, data: rd_word};
    end else if (wr_req) begin
      ANS <= '{err: 1'b0, data: REQ.data};
    end else if (REQ_VALID) begin
      ANS <= '{err: 1'b1, data: `EXC_ILLEGAL_FUNCTION};
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_lo_read;
    rd_req && REQ.addr == `ADDR_FLOW_SELECTED_UNIT_LO;
  endsequence

  sequence s_hi_read;
    rd_req && REQ.addr == `ADDR_FLOW_SELECTED_UNIT_HI;
  endsequence

  sequence s_cmd_write(logic [15:0] code);
    wr_req && REQ.addr == `ADDR_SERVICE_COMMAND && REQ.data == code;
  endsequence

  a_sp_store: assert property (wr_req && REQ.addr == `ADDR_POSITION_SETPOINT
      && REQ.data <= `PERCENT_FULL |=> sp_reg == $past(REQ.data))
    else $error("setpoint write not stored");

  a_sp_range_drop: assert property (wr_req && REQ.addr == `ADDR_POSITION_SETPOINT
      && REQ.data > `PERCENT_FULL |=> $stable(sp_reg))
    else $error("out-of-range setpoint stored");

  a_override_open: assert property (ovr_reg == OVR_OPEN |=> POS_DEMAND == `PERCENT_FULL)
    else $error("open override not applied");

  a_cmd_self_clear: assert property (s_cmd_write(16'h0001) ##1 !wr_req
      |=> cmd_reg == SVC_NONE)
    else $error("command register did not return to none");

  a_fault_clear_pulse: assert property (s_cmd_write(16'h0004)
      |=> ##1 SERVICE.fault_clear ##1 !SERVICE.fault_clear || $past(cmd_reg) != SVC_NONE)
    else $error("clear fault pulse wrong");

  a_sensor_switch: assert property (rd_req && REQ.addr == `ADDR_SENSOR_INPUT_VALUE
      && SENSOR_KIND == `SENSOR_KIND_SWITCH |=> ANS.data == {15'h0000, $past(PLANT.sensor_switch)})
    else $error("switch sensor reading wrong");

  a_unused_ffff: assert property (rd_req && REQ.addr == `ADDR_UNUSED_SLOT
      |=> ANS_VALID && ANS.data == `WORD_UNSUPPORTED)
    else $error("unused register not 65535");

  a_flow_pair: assert property (s_lo_read ##1 s_hi_read
      |=> ANS.data == $past(PLANT.flow_selected_unit[31:16], 2))
    else $error("flow halves from different samples");

  a_answer_next: assert property (REQ_VALID |=> ANS_VALID ##1 (ANS_VALID == $past(REQ_VALID)))
    else $error("answer not one cycle after request");

  a_override_close: assert property (ovr_reg == OVR_CLOSE |=> POS_DEMAND == `PERCENT_ZERO)
    else $error("close override not applied");

  a_override_min: assert property (ovr_reg == OVR_MIN |=> POS_DEMAND == $past(LIMIT_MIN))
    else $error("min override not applied");

  a_override_max: assert property (ovr_reg == OVR_MAX |=> POS_DEMAND == $past(LIMIT_MAX))
    else $error("max override not applied");

  a_demand_bounded: assert property (ovr_reg == OVR_NONE && LIMIT_MIN <= LIMIT_MAX
      |=> POS_DEMAND >= $past(LIMIT_MIN) && POS_DEMAND <= $past(LIMIT_MAX))
    else $error("setpoint demand outside limits");

  a_ovr_range_drop: assert property (wr_req && REQ.addr == `ADDR_OVERRIDE_SELECT
      && REQ.data > 16'(OVR_MAX) |=> $stable(ovr_reg))
    else $error("unknown override code stored");

  a_cmd_range_drop: assert property (wr_req && REQ.addr == `ADDR_SERVICE_COMMAND
      && REQ.data > 16'(SVC_CLEAR_FAULT) |=> cmd_reg == SVC_NONE)
    else $error("unknown command code stored");

  a_ro_write_kept: assert property (wr_req && REQ.addr > `ADDR_SERVICE_COMMAND
      |=> $stable(sp_reg) && $stable(ovr_reg))
    else $error("write to read-only register changed state");

  a_cmd_return: assert property (cmd_reg != SVC_NONE
      && !(wr_req && REQ.addr == `ADDR_SERVICE_COMMAND) |=> cmd_reg == SVC_NONE)
    else $error("command code held too long");

  a_kind_read: assert property (rd_req && REQ.addr == `ADDR_ACTUATOR_KIND
      |=> ANS.data == $past(PLANT.actuator_kind))
    else $error("actuator kind reading wrong");

  a_abs_pos_read: assert property (rd_req && REQ.addr == `ADDR_ABSOLUTE_POSITION
      |=> ANS.data == $past(PLANT.absolute_position))
    else $error("absolute position reading wrong");

  a_rel_flow_read: assert property (rd_req && REQ.addr == `ADDR_RELATIVE_FLOW
      |=> ANS.data == $past(PLANT.relative_flow))
    else $error("relative flow reading wrong");

  a_sensor_active: assert property (rd_req && REQ.addr == `ADDR_SENSOR_INPUT_VALUE
      && SENSOR_KIND == `SENSOR_KIND_ACTIVE |=> ANS.data == $past(PLANT.sensor_millivolt))
    else $error("active sensor reading wrong");

  a_flow_low: assert property (rd_req && REQ.addr == `ADDR_FLOW_SELECTED_UNIT_LO
      |=> ANS.data == $past(PLANT.flow_selected_unit[15:0]))
    else $error("flow low half wrong");

  a_analog_copy: assert property (rd_req && REQ.addr == `ADDR_ANALOG_SETPOINT_COPY
      && PLANT.analog_mode |=> ANS.data == $past(PLANT.analog_setpoint))
    else $error("analog setpoint copy wrong");

  a_bad_function: assert property (REQ_VALID && !rd_req && !wr_req
      |=> ANS.err && ANS.data == `EXC_ILLEGAL_FUNCTION)
    else $error("unsupported function not refused");

endmodule

// *** testbench/fieldbus_master_model.sv ***
// fieldbus master model issuing one decoded request at a time
// assumes the register map answers within a few cycles and never back-pressures
`timescale 1ns/100ps
module fieldbus_master_model
  import actuator_op_pkg::*;
(
  input wire logic clk, // system clock
  output logic req_valid, // request strobe
  output bus_req_t req, // request word
  input wire logic ans_valid, // answer strobe
  input wire bus_ans_t ans // answer word
);
  initial begin
    req_valid = 1'b0;
    req = '0;
  end

  // request stands from one falling edge to the next, so one rising edge takes it
  task automatic access(input logic [7:0] func, input logic [15:0] addr,
                        input logic [15:0] data, output bus_ans_t got, output logic ok);
    int i;
    @(negedge clk);
    req_valid = 1'b1;
    req = {func, addr, data};
    @(negedge clk);
    req_valid = 1'b0;
    // released lines show garbage, not the last request
    req = ~req;
    ok = 1'b0;
    for (i = 0; i < 4 && !ok; i++) begin
      if (i > 0) begin
        @(negedge clk);
      end
      ok = (ans_valid === 1'b1);
    end
    got = ans;
  endtask

  // both halves read back to back, low word first
  // each answer stands one cycle, so it is taken at the negedge after its request
  task automatic read_flow(output logic [31:0] flow, output logic ok);
    @(negedge clk);
    req_valid = 1'b1;
    req = {8'h03, 16'h000A, 16'h0000};
    @(negedge clk);
    req = {8'h03, 16'h000B, 16'h0000};
    ok = (ans_valid === 1'b1);
    flow[15:0] = ans.data;
    @(negedge clk);
    req_valid = 1'b0;
    req = ~req;
    ok = ok && (ans_valid === 1'b1);
    flow[31:16] = ans.data;
  endtask
endmodule

// *** testbench/tb_actuator_operation_register_map.sv ***
// self-checking bench for the operation register map
// assumes the master model and the design sit on one 200 MHz clock
`timescale 1ns/100ps
`include "actuator_op_regs.svh"
module tb_actuator_operation_register_map
  import actuator_op_pkg::*;
;
  logic CLK;
  logic RST;
  logic REQ_VALID;
  bus_req_t REQ;
  logic ANS_VALID;
  bus_ans_t ANS;
  plant_state_t plant;
  logic [15:0] lim_min;
  logic [15:0] lim_max;
  logic [15:0] sensor_kind;
  logic [15:0] POS_DEMAND;
  service_pulse_t SERVICE;
  int miscompares;
  int comparisons;
  bus_ans_t a;
  logic ok;
  logic [31:0] f;
  logic [15:0] ovr_exp [1:5] = '{16'h2710, 16'h0000, 16'h03E8, 16'h1388, 16'h2328};
  logic [3:0] svc_exp [0:4] = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h1};

  actuator_operation_register_map i_actuator_operation_register_map (
    .CLK(CLK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ(REQ), .ANS_VALID(ANS_VALID),
    .ANS(ANS), .PLANT(plant), .LIMIT_MIN(lim_min), .LIMIT_MAX(lim_max),
    .SENSOR_KIND(sensor_kind), .POS_DEMAND(POS_DEMAND), .SERVICE(SERVICE));

  fieldbus_master_model i_fieldbus_master_model (
    .clk(CLK), .req_valid(REQ_VALID), .req(REQ), .ans_valid(ANS_VALID), .ans(ANS));

  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  task automatic results();
    $display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // a lost answer ends the run at once
  task automatic xfer(input logic [7:0] func, input logic [15:0] addr, input logic [15:0] d);
    i_fieldbus_master_model.access(func, addr, d, a, ok);
    if (ok !== 1'b1) begin
      miscompares++;
      $display("Error at %0t: no answer", $time);
      results();
    end
  endtask

  task automatic rd(input logic [15:0] addr, input logic [15:0] exp, input string what);
    xfer(`FUNC_READ_HOLDING, addr, 16'h0000);
    chk(a.data, exp, what);
  endtask

  task automatic wr(input logic [15:0] addr, input logic [15:0] d);
    xfer(`FUNC_WRITE_SINGLE, addr, d);
    chk(a.data, d, "write echo");
  endtask

  initial begin
    RST = 1'b1;
    plant = '0;
    plant.actuator_kind = 16'h0003;
    plant.relative_position = 16'h0FA0;
    plant.absolute_position = 16'h005A;
    plant.relative_flow = 16'h1F40;
    plant.absolute_flow_basic = 16'h0123;
    plant.sensor_millivolt = 16'h2B5C;
    plant.sensor_switch = 1'b1;
    plant.flow_selected_unit = 32'h001338D7;
    plant.analog_setpoint = 16'h1A88;
    lim_min = 16'h03E8;
    lim_max = 16'h2328;
    sensor_kind = `SENSOR_KIND_ACTIVE;
    miscompares = 0;
    comparisons = 0;
    repeat (6) @(negedge CLK);
    RST = 1'b0;
    @(negedge CLK);
    chk(POS_DEMAND, 16'h03E8, "reset demand");
    rd(16'h0000, 16'h0000, "setpoint reset");
    rd(16'h0001, 16'h0000, "override reset");
    rd(16'h0002, 16'h0000, "command reset");
    $display("test reset values done");
    wr(16'h0000, 16'h1388);
    @(negedge CLK);
    chk(POS_DEMAND, 16'h1388, "demand");
    wr(16'h0000, 16'h2711);
    rd(16'h0000, 16'h1388, "setpoint range");
    wr(16'h0000, `PERCENT_FULL);
    @(negedge CLK);
    chk(POS_DEMAND, 16'h2328, "clamp max");
    $display("test setpoint done");
    for (int k = 1; k <= 5; k++) begin
      wr(16'h0001, 16'(k));
      @(negedge CLK);
      chk(POS_DEMAND, ovr_exp[k], "override demand");
    end
    wr(16'h0001, 16'h0006);
    rd(16'h0001, 16'h0005, "override range");
    wr(16'h0001, 16'h0000);
    $display("test override done");
    for (int k = 0; k <= 4; k++) begin
      wr(16'h0002, 16'(k));
      @(negedge CLK);
      chk(16'(SERVICE), 16'(svc_exp[k]), "service pulse");
      @(negedge CLK);
      chk(16'(SERVICE), 16'h0000, "pulse width");
      rd(16'h0002, 16'h0000, "command self clear");
    end
    wr(16'h0002, 16'h0005);
    @(negedge CLK);
    chk(16'(SERVICE), 16'h0000, "bad command");
    $display("test command done");
    wr(16'h0003, 16'h0000);
    rd(16'h0003, 16'h0003, "actuator kind");
    rd(16'h0004, 16'h0FA0, "relative position");
    rd(16'h0005, 16'h005A, "absolute position");
    rd(16'h0006, 16'h1F40, "relative flow");
    rd(16'h0007, 16'h0123, "basic flow");
    $display("test read-only done");
    rd(16'h0008, 16'h2B5C, "sensor mV");
    sensor_kind = `SENSOR_KIND_SWITCH;
    rd(16'h0008, 16'h0001, "sensor switch");
    sensor_kind = 16'h0000;
    rd(16'h0008, `WORD_UNSUPPORTED, "sensor none");
    rd(16'h0009, `WORD_UNSUPPORTED, "unused slot");
    rd(16'h000C, `WORD_UNSUPPORTED, "analog off");
    plant.analog_mode = 1'b1;
    rd(16'h000C, 16'h1A88, "analog copy");
    rd(16'h0040, `WORD_UNSUPPORTED, "unmapped");
    $display("test sensor and unsupported done");
    i_fieldbus_master_model.read_flow(f, ok);
    chk({15'h0000, ok}, 16'h0001, "flow answer");
    chk(f[15:0], 16'h38D7, "flow low");
    chk(f[31:16], 16'h0013, "flow high");
    rd(16'h000A, 16'h38D7, "flow low again");
    plant.flow_selected_unit = 32'h00140000;
    rd(16'h000B, 16'h0013, "held high half");
    rd(16'h000B, 16'h0014, "live high half");
    $display("test flow pair done");
    xfer(`FUNC_READ_INPUT, 16'h0005, 16'h0000);
    chk(a.data, 16'h005A, "input read");
    xfer(8'h10, 16'h0000, 16'h0001);
    chk({15'h0000, a.err}, 16'h0001, "exception flag");
    chk(a.data, `EXC_ILLEGAL_FUNCTION, "exception code");
    rd(16'h0000, `PERCENT_FULL, "setpoint kept");
    $display("test functions done");
    results();
  end
endmodule
